// ### hw/dpot_regs.svh
`ifndef DPOT_REGS_SVH
`define DPOT_REGS_SVH
// Word layout: command in the top nibble, address next, data in the low byte.
`define DPOT_WORD_W      16
`define DPOT_CMD_MSB     15
`define DPOT_CMD_LSB     12
`define DPOT_ADDR_MSB    11
`define DPOT_ADDR_LSB    8
`define DPOT_DATA_MSB    7
`define DPOT_DATA_LSB    0
`define DPOT_CHAN_BIT    8
// Nonvolatile cell count and the reset value of every cell (midscale).
`define DPOT_NV_CELLS    16
`define DPOT_NV_RESET    8'h80
// Save time to nonvolatile storage, in microseconds, and the clock rate in kHz.
`define DPOT_SAVE_US     25000
`define DPOT_CLK_KHZ     20000
`define DPOT_SAVE_CYC    ((`DPOT_SAVE_US * `DPOT_CLK_KHZ) / 1000)
`endif

// ### hw/dpot_pkg.sv
package dpot_pkg;
   // Instruction codes carried in the command field.
   typedef enum logic [3:0] {
      DPOT_IDLE     = 4'h0,
      DPOT_NV_LOAD  = 4'h1,
      DPOT_NV_SAVE  = 4'h2,
      DPOT_NV_WRITE = 4'h3,
      DPOT_SHR_ONE  = 4'h4,
      DPOT_SHR_ALL  = 4'h5,
      DPOT_DEC_ONE  = 4'h6,
      DPOT_DEC_ALL  = 4'h7,
      DPOT_RESTORE  = 4'h8,
      DPOT_NV_READ  = 4'h9,
      DPOT_WP_READ  = 4'hA,
      DPOT_WP_WRITE = 4'hB,
      DPOT_SHL_ONE  = 4'hC,
      DPOT_SHL_ALL  = 4'hD,
      DPOT_INC_ONE  = 4'hE,
      DPOT_INC_ALL  = 4'hF
   } dpot_cmd_t;
   // Power state of the device.
   typedef enum logic [1:0] {
      DPOT_PWR_IDLE,
      DPOT_PWR_READ,
      DPOT_PWR_ACTIVE
   } dpot_pwr_t;
endpackage

// ### hw/dpot_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a single level from outside the clock domain.
module dpot_sync (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic async_in,
   input  wire logic rst_val,
   output logic      sync_out
);
   // First stage, read only by the second stage.
   logic meta_q;
   // Both stages load the idle level under reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q   <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ### hw/dpot_wiper_alu.sv
`timescale 1ns/100ps
// Computes the next value of one wiper for an adjust command.
module dpot_wiper_alu (
   input  wire logic [3:0] op,
   input  wire logic [7:0] cur,
   output logic      [7:0] nxt
);
   // Saturating step and shift arithmetic.
   always_comb begin
      unique case (op)
         4'h4, 4'h5: nxt = {1'b0, cur[7:1]};
         4'h6, 4'h7: nxt = (cur == 8'h00) ? 8'h00 : cur - 8'h01;
         4'hC, 4'hD: begin
            if (cur == 8'h00) nxt = 8'h01;
            else if (cur[7]) nxt = 8'hFF;
            else nxt = {cur[6:0], 1'b0};
         end
         4'hE, 4'hF: nxt = (cur == 8'hFF) ? 8'hFF : cur + 8'h01;
         default:    nxt = cur;
      endcase
   end
endmodule

// ### hw/dpot_decoder.sv
`timescale 1ns/100ps
`include "dpot_regs.svh"
// Summary of operation
// - Word: command nibble, address nibble, data byte.
// - Execute only when chip select rises.
// - Command zero does nothing, enters idle power.
// - Command one loads cell to wiper, read power.
// - Command two saves wiper into its cell.
// - Command three writes data byte to cell.
// - Command four halves selected wiper.
// - Command five halves both wipers.
// - Command six decrements selected wiper, floor zero.
// - Command seven decrements both wipers, floor zero.
// - Command eight reloads both wipers from cells.
// - Command nine loads cell into readback byte.
// - Command ten loads wiper into readback byte.
// - Command eleven writes data byte to wiper.
// - Command twelve doubles selected wiper, saturating.
// - Command thirteen doubles both wipers, saturating.
// - Command fourteen increments selected wiper, ceiling.
// - Command fifteen increments both wipers, ceiling.
// - Adjust commands ignore the data byte.
// - Serial out delays input by register length.
// - Wipers reload from cells at power-up.
// - A save takes up to 25 ms.
// - Empty strobes repeat the last command, if it was an adjust command.
// - Left shift: zero gives one, high gives full.
// - Serial out released while chip select high.
module dpot_decoder #(
   parameter int SAVE_CYC = `DPOT_SAVE_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       sclk_pin,
   input  wire logic       cs_n_pin,
   input  wire logic       sdi_pin,
   output logic            serial_out_pin_o,
   output logic            serial_out_pin_oe,
   output logic [7:0]      wiper0,
   output logic [7:0]      wiper1,
   output logic            save_busy,
   output dpot_pkg::dpot_pwr_t pwr_state
);
   localparam int NVC = `DPOT_NV_CELLS;

   // Synchronised pin levels.
   logic sclk_s;
   logic cs_n_s;
   logic sdi_s;
   dpot_sync u_sync_clk (.clk_sys(clk_sys), .rst(rst), .async_in(sclk_pin),
                         .rst_val(1'b0), .sync_out(sclk_s));
   dpot_sync u_sync_sdi (.clk_sys(clk_sys), .rst(rst), .async_in(sdi_pin),
                         .rst_val(1'b0), .sync_out(sdi_s));
   // Chip select idles high, so its synchroniser resets to the deselected level.
   dpot_sync u_sync_cs (.clk_sys(clk_sys), .rst(rst), .async_in(cs_n_pin),
                        .rst_val(1'b1), .sync_out(cs_n_s));

   // Edge history of the synchronised link clock and chip select.
   logic sclk_q;
   logic cs_n_q;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= sclk_s;
         cs_n_q <= cs_n_s;
      end
   end
   // Rising link-clock edge inside a frame samples input; falling shifts output.
   logic rise;
   logic fall;
   logic cs_rise;
   assign rise    = sclk_s & ~sclk_q & ~cs_n_s;
   assign fall    = ~sclk_s & sclk_q & ~cs_n_s;
   assign cs_rise = cs_n_s & ~cs_n_q;

   // Shift register, bit counter and output bit.
   logic [15:0] shreg_q;
   logic [4:0]  bits_q;
   logic        out_bit_q;
   logic        rd_load;
   logic [7:0]  rd_byte;

   // Serial shift register: MSB first in, readback byte loaded on execution.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shreg_q <= 16'h0000;
      end else if (rise) begin
         shreg_q <= {shreg_q[14:0], sdi_s};
      end else if (rd_load) begin
         shreg_q <= {shreg_q[15:8], rd_byte};
      end
   end

   // Counts bits of the current frame; cleared when the frame ends.
   always_ff @(posedge clk_sys) begin
      if (rst || cs_n_s) begin
         bits_q <= 5'h00;
      end else if (rise && bits_q != 5'h1F) begin
         bits_q <= bits_q + 5'h01;
      end
   end

   // Output bit follows the shift register MSB, updated on falling edges.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_bit_q <= 1'b1;
      end else if (cs_n_s || fall) begin
         out_bit_q <= shreg_q[15];
      end
   end
   // Open drain: pull low only for a zero bit while selected.
   assign serial_out_pin_o  = 1'b0;
   assign serial_out_pin_oe = ~cs_n_s & ~out_bit_q;

   // Decoded fields of the received word.
   dpot_pkg::dpot_cmd_t cmd;
   logic [3:0]  addr;
   logic [7:0]  data;
   logic        chan;
   assign cmd  = dpot_pkg::dpot_cmd_t'(shreg_q[`DPOT_CMD_MSB:`DPOT_CMD_LSB]);
   assign addr = shreg_q[`DPOT_ADDR_MSB:`DPOT_ADDR_LSB];
   assign data = shreg_q[`DPOT_DATA_MSB:`DPOT_DATA_LSB];
   assign chan = shreg_q[`DPOT_CHAN_BIT];

   // Adjust command remembered for repeats on empty strobes.
   logic [3:0] last_adj_q;
   logic       rep_ok_q;
   logic       rep_chan_q;  // Wiper chosen by the remembered command.
   logic       new_word;
   logic       exec;
   logic [3:0] op;
   logic       op_chan;
   assign new_word = (bits_q >= 5'h10);
   assign exec     = cs_rise && (new_word || rep_ok_q);
   assign op       = new_word ? cmd : last_adj_q;
   assign op_chan  = new_word ? chan : rep_chan_q;

   // Adjust commands are the shift and step codes.
   function automatic logic is_adj(input logic [3:0] c);
      is_adj = (c >= 4'h4 && c <= 4'h7) || (c >= 4'hC);
   endfunction
   function automatic logic is_both(input logic [3:0] c);
      is_both = c[0];
   endfunction

   // Records the adjust command for later repeats.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         last_adj_q <= 4'h0;
         rep_ok_q   <= 1'b0;
         rep_chan_q <= 1'b0;
      end else if (cs_rise && new_word) begin
         last_adj_q <= shreg_q[15:12];
         rep_ok_q   <= is_adj(shreg_q[15:12]);
         rep_chan_q <= chan;
      end
   end

   // Nonvolatile cells, all at midscale after reset.
   logic [7:0] nv_q [NVC];
   logic [7:0] w_q  [2];
   logic [7:0] alu_out [2];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_alu
         dpot_wiper_alu u_alu (.op(op), .cur(w_q[gi]), .nxt(alu_out[gi]));
      end
   endgenerate

   // Readback selection for commands nine and ten.
   assign rd_load = exec && new_word && (op == 4'h9 || op == 4'hA);
   assign rd_byte = (op == 4'h9) ? nv_q[addr] : w_q[chan];

   // Save timer: counts down the nonvolatile write time.
   logic [$clog2(SAVE_CYC+1)-1:0] save_cnt_q;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         save_cnt_q <= '0;
      end else if (exec && new_word && (op == 4'h2 || op == 4'h3)) begin
         save_cnt_q <= ($clog2(SAVE_CYC+1))'(SAVE_CYC);
      end else if (save_cnt_q != '0) begin
         save_cnt_q <= save_cnt_q - 1'b1;
      end
   end
   assign save_busy = (save_cnt_q != '0);

   // Nonvolatile cell updates for save and user write.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < NVC; i++) nv_q[i] <= `DPOT_NV_RESET;
      end else if (exec && new_word) begin
         if (op == 4'h2) nv_q[{3'h0, chan}] <= w_q[chan];
         else if (op == 4'h3) nv_q[addr] <= data;
      end
   end

   // Wiper updates; reset models power-up refresh from the cells.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         w_q[0] <= `DPOT_NV_RESET;
         w_q[1] <= `DPOT_NV_RESET;
      end else if (exec) begin
         if (new_word && op == 4'h1) begin
            w_q[chan] <= nv_q[{3'h0, chan}];
         end else if (new_word && op == 4'h8) begin
            w_q[0] <= nv_q[0];
            w_q[1] <= nv_q[1];
         end else if (new_word && op == 4'hB) begin
            w_q[chan] <= data;
         end else if (is_adj(op)) begin
            if (is_both(op)) begin
               w_q[0] <= alu_out[0];
               w_q[1] <= alu_out[1];
            end else begin
               w_q[op_chan] <= alu_out[op_chan];
            end
         end
      end
   end
   assign wiper0 = w_q[0];
   assign wiper1 = w_q[1];

   // Power state: idle after command zero, read after command one.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwr_state <= dpot_pkg::DPOT_PWR_IDLE;
      end else if (exec && new_word) begin
         unique case (op)
            4'h0:    pwr_state <= dpot_pkg::DPOT_PWR_IDLE;
            4'h1:    pwr_state <= dpot_pkg::DPOT_PWR_READ;
            default: if (pwr_state != dpot_pkg::DPOT_PWR_READ)
                        pwr_state <= dpot_pkg::DPOT_PWR_ACTIVE;
         endcase
      end
   end

   // Nothing executes while chip select is low.
   chk_exec_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
      exec |-> cs_n_s && !cs_n_q)
      else $error("execution without chip select rising");
   // Output released whenever deselected.
   chk_out_release: assert property (@(posedge clk_sys) disable iff (rst)
      cs_n_s |-> !serial_out_pin_oe)
      else $error("serial out driven while deselected");
   // Idle command returns to idle power.
   chk_idle_power: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && new_word && op == 4'h0) |=> pwr_state == dpot_pkg::DPOT_PWR_IDLE)
      else $error("idle command did not reach idle power");
   // Wiper write takes the data byte.
   chk_wiper_write: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && new_word && op == 4'hB && !chan) |=> wiper0 == $past(data))
      else $error("wiper write lost data");
   // Increment saturates at full scale.
   chk_inc_sat: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && op == 4'hE && !op_chan && wiper0 == 8'hFF) |=> wiper0 == 8'hFF)
      else $error("increment wrapped");
   // Decrement holds at zero.
   chk_dec_floor: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && op == 4'h7 && wiper0 == 8'h00) |=> wiper0 == 8'h00)
      else $error("decrement wrapped");
   // Save starts the busy timer.
   chk_save_busy: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && new_word && op == 4'h2) |=> save_busy [*8])
      else $error("save not busy");
   // Readback places the wiper in the low byte.
   chk_readback: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_load && op == 4'hA && !chan) |=> shreg_q[7:0] == wiper0)
      else $error("readback byte wrong");
   // A full word executes on the chip-select rise.
   sequence s_exec_word;
      exec && new_word;
   endsequence
   // An empty strobe arrives while an adjust command is remembered.
   sequence s_empty_strobe;
      cs_rise && !new_word && rep_ok_q;
   endsequence
   // Wipers never move while a frame is still open.
   chk_hold_in_frame: assert property (@(posedge clk_sys) disable iff (rst)
      !cs_n_s |=> $stable(wiper0) && $stable(wiper1))
      else $error("wiper moved inside a frame");
   // User write lands the data byte in the addressed cell.
   chk_nv_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_exec_word ##0 (op == 4'h3) |=> nv_q[$past(addr)] == $past(data))
      else $error("cell write lost data");
   // Halve-all shifts both wipers right together.
   chk_both_halve: assert property (@(posedge clk_sys) disable iff (rst)
      s_exec_word ##0 (op == 4'h5) |=>
         wiper0 == {1'b0, $past(wiper0[7:1])} && wiper1 == {1'b0, $past(wiper1[7:1])})
      else $error("halve all wrong");
   // Restore reloads both wipers from their cells.
   chk_restore_both: assert property (@(posedge clk_sys) disable iff (rst)
      s_exec_word ##0 (op == 4'h8) |=>
         wiper0 == $past(nv_q[0]) && wiper1 == $past(nv_q[1]))
      else $error("restore did not reload wipers");
   // Cell load leaves the device in read power.
   chk_load_power: assert property (@(posedge clk_sys) disable iff (rst)
      s_exec_word ##0 (op == 4'h1) |=> pwr_state == dpot_pkg::DPOT_PWR_READ)
      else $error("cell load did not enter read power");
   // An empty strobe repeats a remembered increment of both wipers.
   chk_repeat_step: assert property (@(posedge clk_sys) disable iff (rst)
      s_empty_strobe ##0 (last_adj_q == 4'hF && wiper1 != 8'hFF) |=>
         wiper1 == $past(wiper1) + 8'h01)
      else $error("empty strobe did not repeat");
endmodule

// ### tb/dpot_host.sv
`timescale 1ns/100ps
// Host model: link master in mode 0 with a 400 ns link clock.
module dpot_host (
   input  wire logic clk_sys,
   input  wire logic sdo_line,
   output logic      sclk_pin,
   output logic      cs_n_pin,
   output logic      sdi_pin
);
   // The link rests with its clock low and the device deselected.
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      sdi_pin  = 1'b0;
   end
   // Waits n system clocks, then steps past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Sends nb bits of w, MSB first; nb of 0 gives an empty strobe.
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] rd);
      rd = 16'h0000;
      tick(1);
      cs_n_pin = 1'b0;
      tick(4);
      for (int i = 0; i < nb; i++) begin
         sdi_pin = w[15-i];
         tick(4);
         rd = {rd[14:0], sdo_line};
         sclk_pin = 1'b1;
         tick(4);
         sclk_pin = 1'b0;
      end
      tick(4);
      cs_n_pin = 1'b1;
      // A released data line shows no stale value.
      sdi_pin = ~sdi_pin;
      tick(4);
   endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
   logic                clk_sys = 1'b0; // System clock.
   logic                rst = 1'b1;     // Synchronous reset.
   logic                sclk_pin;       // Link clock from host.
   logic                cs_n_pin;       // Chip select, active low.
   logic                sdi_pin;        // Serial data in.
   logic                so_o;           // Open-drain value.
   logic                so_oe;          // Open-drain enable.
   logic                sdo_line;       // Resolved output wire.
   logic [7:0]          w0;             // First wiper.
   logic [7:0]          w1;             // Second wiper.
   logic                busy;           // Save in progress.
   dpot_pkg::dpot_pwr_t pwr;            // Power state.
   logic [15:0]         rd;             // Word read back.
   int                  err_count = 0;  // Mismatches.
   int                  num_checks = 0; // Comparisons.
   // Start values, word, expected values for the adjust commands.
   logic [47:0]         adj_tab [11] = '{48'h0310_40FF_0110, 48'h01FF_5FFF_007F,
      48'h0005_60FF_0005, 48'h0005_61FF_0004, 48'h0005_7FFF_0004, 48'h0000_C1FF_0001,
      48'h8041_DFFF_FF82, 48'h7F00_C0FF_FE00, 48'hFF10_E0FF_FF10, 48'hFF10_E1FF_FF11,
      48'hFF10_FFFF_FF11};
   // The line has a pull-up, so it only goes low while driven.
   assign sdo_line = (so_oe === 1'b1 && so_o === 1'b0) ? 1'b0 : 1'b1;
   // Clock of 50 ns period.
   always #25 clk_sys = ~clk_sys;
   dpot_decoder #(.SAVE_CYC(20)) i_dpot_decoder (
      .clk_sys(clk_sys), .rst(rst), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
      .sdi_pin(sdi_pin), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
      .wiper0(w0), .wiper1(w1), .save_busy(busy), .pwr_state(pwr));
   dpot_host i_dpot_host (
      .clk_sys(clk_sys), .sdo_line(sdo_line), .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin), .sdi_pin(sdi_pin));
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Sends one full word and lets it execute.
   task automatic send(input logic [15:0] w);
      i_dpot_host.xfer(w, 16, rd);
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK(so_oe, 1'b0)
   endtask
   // Loads both wipers directly.
   task automatic set_w(input logic [7:0] a, input logic [7:0] b);
      send({8'hB0, a});
      send({8'hB1, b});
   endtask
   // Waits for a save to finish, within a bound.
   task automatic wait_save();
      int n;
      n = 0;
      `CHK(busy, 1'b1)
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 200) begin
         err_count++;
         end_of_test();
      end
   endtask
   // Reset state: wipers at midscale, no save busy, idle power.
   task automatic t_reset();
      `CHK(w0, 8'h80)
      `CHK(w1, 8'h80)
      `CHK(busy, 1'b0)
      `CHK(pwr, dpot_pkg::DPOT_PWR_IDLE)
      $display("test reset done");
   endtask
   // Direct write, chained output and wiper readback.
   task automatic t_readback();
      send(16'hB040);
      `CHK(w0, 8'h40)
      send(16'hA000);
      `CHK(rd, 16'hB040)
      send(16'h0000);
      `CHK(rd[7:0], 8'h40)
      $display("test readback done");
   endtask
   // Every adjust command, with boundary values and a full data byte.
   task automatic t_adjust();
      foreach (adj_tab[i]) begin
         set_w(adj_tab[i][47:40], adj_tab[i][39:32]);
         send(adj_tab[i][31:16]);
         `CHK(w0, adj_tab[i][15:8])
         `CHK(w1, adj_tab[i][7:0])
      end
      $display("test adjust done");
   endtask
   // An empty strobe repeats the last adjust command.
   task automatic t_repeat();
      i_dpot_host.xfer(16'h0000, 0, rd);
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK(w1, 8'h12)
      `CHK(w0, 8'hFF)
      $display("test repeat done");
   endtask
   // Cell write and read, save, load, restore and power states.
   task automatic t_nv();
      send(16'h353C);
      wait_save();
      send(16'h9500);
      send(16'h0000);
      `CHK(rd[7:0], 8'h3C)
      set_w(8'h55, 8'h66);
      send(16'h2000);
      wait_save();
      send(16'h2100);
      wait_save();
      set_w(8'h11, 8'h22);
      send(16'h1000);
      `CHK(w0, 8'h55)
      `CHK(w1, 8'h22)
      `CHK(pwr, dpot_pkg::DPOT_PWR_READ)
      send(16'h0000);
      `CHK(pwr, dpot_pkg::DPOT_PWR_IDLE)
      send(16'h8000);
      `CHK(w0, 8'h55)
      `CHK(w1, 8'h66)
      $display("test nonvolatile done");
   endtask
   // Main sequence: reset for 8 cycles, then the scenarios.
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      t_reset();
      t_readback();
      t_adjust();
      t_repeat();
      t_nv();
      end_of_test();
   end
   // Cuts a hang short.
   initial begin
      #3000000;
      err_count++;
      end_of_test();
   end
endmodule
